// ==== rtl/dagen_pkg.sv ====
// Purpose: shared constants and types for the data address generator
// Assumes: 16-bit working registers, 23-bit program counter
// Notes: word-aligned stack stepping by two byte addresses, byte-addressed data space
package dagen_pkg;

   localparam int DW = 16;
   localparam int NREG = 16;
   localparam logic [3:0] SP_IDX = 4'hF;
   localparam logic [3:0] FP_IDX = 4'hE;
   localparam logic [3:0] DEFAULT_WORKING_ALIAS_IDX = 4'h0;
   localparam logic [15:0] SP_RESET = 16'h1000;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] NEAR_MASK = 16'h1FFF;
   localparam int FADDR_W = 13;
   localparam int LIT5_W = 5;
   localparam int LIT10_W = 10;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] EDS_BIT = 16'h8000;

   // addressing modes
   typedef enum logic [2:0] {
      AM_DIRECT   = 3'b000,
      AM_IND      = 3'b001,
      AM_POST     = 3'b010,
      AM_PRE      = 3'b011,
      AM_INDEXED  = 3'b100,
      AM_LITOFF   = 3'b101,
      AM_LITERAL  = 3'b110,
      AM_FILE     = 3'b111
   } dagen_mode_t;

   // instruction classes
   typedef enum logic [1:0] {
      IC_FILE   = 2'b00,
      IC_THREE  = 2'b01,
      IC_MOVE   = 2'b10,
      IC_OTHER  = 2'b11
   } dagen_class_t;

   // stack sequencer operations
   typedef enum logic [2:0] {
      SO_NONE  = 3'b000,
      SO_PUSH  = 3'b001,
      SO_POP   = 3'b010,
      SO_CALL  = 3'b011,
      SO_TRAP  = 3'b100,
      SO_RET   = 3'b101
   } dagen_stkop_t;

   typedef struct packed {
      dagen_class_t cls;
      dagen_mode_t mode;
      logic [3:0] ptr_sel;
      logic [3:0] base_sel;
      logic signed [15:0] modifier;
      logic [15:0] literal;
      logic [12:0] faddr;
      logic is_mul;
      logic to_default_working_alias;
   } dagen_req_t;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic eds_ok;
      logic is_lit;
      logic [15:0] lit;
      logic [3:0] dest_reg;
      logic dest_is_reg;
      logic bad_mode;
   } dagen_ea_t;

   typedef struct packed {
      logic we;
      logic re;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dagen_mem_t;

endpackage : dagen_pkg

// ==== rtl/dagen_calc.sv ====
// Purpose: combinational effective address calculator
// Assumes: register values already read by the caller
// Notes: no state; stack and active frame addresses never paged
`timescale 1ns/1ps
module dagen_calc (
   // request
   input wire dagen_pkg::dagen_req_t req,
   input wire logic [15:0] pointer_reg,
   input wire logic [15:0] base_operand_reg,
   input wire logic frame_pointer_active_flag,
   // result
   output dagen_pkg::dagen_ea_t ea,
   output logic ptr_wb,
   output logic [15:0] ptr_new
);

   function automatic logic mode_legal(dagen_pkg::dagen_class_t c,
                                       dagen_pkg::dagen_mode_t m);
      logic ok;
      ok = 1'b0;
      case (c)
         dagen_pkg::IC_FILE: ok = (m == dagen_pkg::AM_FILE);
         dagen_pkg::IC_THREE: ok = (m == dagen_pkg::AM_DIRECT) ||
            (m == dagen_pkg::AM_IND) || (m == dagen_pkg::AM_POST) ||
            (m == dagen_pkg::AM_PRE) ||
            (m == dagen_pkg::AM_LITERAL);
         // move takes every mode, indexed and whole-space file form too
         dagen_pkg::IC_MOVE: ok = 1'b1;
         default: ok = 1'b1;
      endcase
      return ok;
   endfunction : mode_legal

   logic [15:0] sum;
   logic unpaged;

   always_comb begin
      ea = '0;
      ptr_wb = 1'b0;
      ptr_new = pointer_reg;
      sum = pointer_reg;
      ea.valid = 1'b1;
      ea.bad_mode = !mode_legal(req.cls, req.mode);
      ea.dest_reg = req.ptr_sel;
      case (req.mode)
         dagen_pkg::AM_FILE: begin
            // move reaches the whole space, others only the near region
            if (req.cls == dagen_pkg::IC_MOVE) begin
               sum = req.literal;
            end else begin
               sum = {3'b000, req.faddr};
            end
            ea.dest_reg = dagen_pkg::DEFAULT_WORKING_ALIAS_IDX;
            ea.dest_is_reg = req.to_default_working_alias || req.is_mul;
         end
         dagen_pkg::AM_DIRECT: begin
            ea.is_lit = 1'b1;
            ea.lit = pointer_reg;
            ea.dest_is_reg = 1'b1;
         end
         dagen_pkg::AM_IND: sum = pointer_reg;
         dagen_pkg::AM_POST: begin
            sum = pointer_reg;
            ptr_wb = 1'b1;
            ptr_new = pointer_reg + req.modifier;
         end
         dagen_pkg::AM_PRE: begin
            sum = pointer_reg + req.modifier;
            ptr_wb = 1'b1;
            ptr_new = sum;
         end
         dagen_pkg::AM_INDEXED: sum = pointer_reg + base_operand_reg;
         dagen_pkg::AM_LITOFF: sum = pointer_reg + req.literal;
         dagen_pkg::AM_LITERAL: begin
            ea.is_lit = 1'b1;
            // three-operand literal is taken as 10 bits wide
            ea.lit = (req.cls == dagen_pkg::IC_THREE) ?
               {6'h00, req.literal[dagen_pkg::LIT10_W-1:0]} :
               req.literal;
         end
         default: sum = pointer_reg;
      endcase
      ea.addr = sum;
      unpaged = (req.ptr_sel == dagen_pkg::SP_IDX) ||
         (req.ptr_sel == dagen_pkg::FP_IDX && frame_pointer_active_flag);
      ea.eds_ok = !unpaged && !ea.is_lit &&
         (req.mode != dagen_pkg::AM_DIRECT);
   end

endmodule : dagen_calc

// ==== rtl/dagen_core.sv ====
// Purpose: working register file, stack sequencer and address path
// Assumes: decode presents one request per cycle with a valid strobe
// Notes: stack frames of two words take two cycles
`timescale 1ns/1ps

// Notes on behaviour
// - stack pointer auto-updated, still ordinary register
// - stack pointer bit zero forced zero
// - reset loads stack pointer with 0x1000
// - push writes then increments, pop predecrements
// - pc low word first, upper bits next
// - call zero-fills upper byte of second word
// - exception joins status low byte to pc
// - stack and active frame never paged
// - file field thirteen bits, near region
// - file ops default to working register zero
// - three-operand first operand register direct only
// - three-operand mode subset enforced
// - plain indirect uses pointer unchanged
// - post-modify uses old value then adjusts
// - pre-modify adjusts then uses
// - indexed adds pointer and base register
// - literal offset adds pointer and literal
// - move also allows indexed mode
// - move source and destination share offset field
// - move reaches entire data space
module dagen_core (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // decode request
   input wire logic req_valid,
   input wire dagen_pkg::dagen_req_t src_req,
   input wire dagen_pkg::dagen_req_t dst_req,
   input wire logic dst_used,
   // register write from the datapath
   input wire logic wr_en,
   input wire logic [3:0] wr_sel,
   input wire logic [15:0] wr_data,
   // stack operations
   input wire dagen_pkg::dagen_stkop_t stk_op,
   input wire logic [22:0] pc_in,
   input wire logic [15:0] push_data,
   input wire logic [7:0] status_low_byte,
   input wire logic frame_pointer_active_flag,
   // memory read data
   input wire logic [15:0] mem_rdata,
   // address results
   output dagen_pkg::dagen_ea_t src_ea,
   output dagen_pkg::dagen_ea_t dst_ea,
   output logic req_ready,
   // stack memory access and pop results
   output dagen_pkg::dagen_mem_t stk_mem,
   output logic pop_valid,
   output logic [15:0] pop_data,
   output logic [22:0] pc_out,
   output logic [7:0] status_out,
   output logic [15:0] stack_pointer
);

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_HI    = 3'b001,
      ST_RLO   = 3'b010,
      ST_RHI   = 3'b011,
      ST_POP   = 3'b100
   } dagen_state_t;

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [15:0] regs_q [dagen_pkg::NREG];
   logic [15:0] regs_d [dagen_pkg::NREG];

   dagen_state_t state_q, state_d;
   logic [15:0] hi_word_q, hi_word_d;
   logic [6:0] pc_hi_q, pc_hi_d;
   dagen_pkg::dagen_ea_t src_ea_q, src_ea_d, dst_ea_q, dst_ea_d;
   dagen_pkg::dagen_mem_t mem_q, mem_d;
   logic pop_valid_q, pop_valid_d;
   logic [15:0] pop_data_q, pop_data_d;
   logic [22:0] pc_out_q, pc_out_d;
   logic [7:0] status_q, status_d;

   logic src_wb, dst_wb;
   logic [15:0] src_new, dst_new;
   dagen_pkg::dagen_ea_t src_c, dst_c;
   dagen_pkg::dagen_req_t dst_fix;

   // one shared offset field: destination sees the source base register
   always_comb begin
      dst_fix = dst_req;
      dst_fix.base_sel = src_req.base_sel;
   end

   dagen_calc u_src (
      .req(src_req),
      .pointer_reg(regs_q[src_req.ptr_sel]),
      .base_operand_reg(regs_q[src_req.base_sel]),
      .frame_pointer_active_flag(frame_pointer_active_flag),
      .ea(src_c),
      .ptr_wb(src_wb),
      .ptr_new(src_new)
   );

   dagen_calc u_dst (
      .req(dst_fix),
      .pointer_reg(regs_q[dst_fix.ptr_sel]),
      .base_operand_reg(regs_q[dst_fix.base_sel]),
      .frame_pointer_active_flag(frame_pointer_active_flag),
      .ea(dst_c),
      .ptr_wb(dst_wb),
      .ptr_new(dst_new)
   );

   logic [15:0] sp;
   assign sp = regs_q[dagen_pkg::SP_IDX];

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < dagen_pkg::NREG; i++) begin
         regs_d[i] = regs_q[i];
      end
      state_d = state_q;
      hi_word_d = hi_word_q;
      pc_hi_d = pc_hi_q;
      src_ea_d = src_ea_q;
      dst_ea_d = dst_ea_q;
      mem_d = '0;
      pop_valid_d = 1'b0;
      pop_data_d = pop_data_q;
      pc_out_d = pc_out_q;
      status_d = status_q;
      src_ea_d.valid = 1'b0;
      dst_ea_d.valid = 1'b0;

      // datapath writes: any instruction may touch the stack pointer
      if (wr_en) begin
         regs_d[wr_sel] = wr_data;
      end

      case (state_q)
         ST_IDLE: begin
            if (stk_op == dagen_pkg::SO_PUSH) begin
               mem_d = '{we: 1'b1, re: 1'b0, addr: sp,
                         wdata: push_data};
               regs_d[dagen_pkg::SP_IDX] = sp + dagen_pkg::WORD_STEP;
            end else if (stk_op == dagen_pkg::SO_CALL ||
                         stk_op == dagen_pkg::SO_TRAP) begin
               mem_d = '{we: 1'b1, re: 1'b0, addr: sp,
                         wdata: pc_in[15:0]};
               regs_d[dagen_pkg::SP_IDX] = sp + dagen_pkg::WORD_STEP;
               if (stk_op == dagen_pkg::SO_CALL) begin
                  hi_word_d = {9'h000, pc_in[22:16]};
               end else begin
                  hi_word_d = {status_low_byte, 1'b0,
                               pc_in[22:16]};
               end
               state_d = ST_HI;
            end else if (stk_op == dagen_pkg::SO_RET) begin
               regs_d[dagen_pkg::SP_IDX] = sp - dagen_pkg::WORD_STEP;
               mem_d = '{we: 1'b0, re: 1'b1,
                         addr: sp - dagen_pkg::WORD_STEP,
                         wdata: 16'h0000};
               state_d = ST_RHI;
            end else if (stk_op == dagen_pkg::SO_POP) begin
               regs_d[dagen_pkg::SP_IDX] = sp - dagen_pkg::WORD_STEP;
               mem_d = '{we: 1'b0, re: 1'b1,
                         addr: sp - dagen_pkg::WORD_STEP,
                         wdata: 16'h0000};
               state_d = ST_POP;
            end else if (req_valid) begin
               src_ea_d = src_c;
               dst_ea_d = dst_c;
               dst_ea_d.valid = dst_used;
               if (src_wb) begin
                  regs_d[src_req.ptr_sel] = src_new;
               end
               if (dst_used && dst_wb) begin
                  regs_d[dst_fix.ptr_sel] = dst_new;
               end
            end
         end
         ST_HI: begin
            mem_d = '{we: 1'b1, re: 1'b0, addr: sp,
                      wdata: hi_word_q};
            regs_d[dagen_pkg::SP_IDX] = sp + dagen_pkg::WORD_STEP;
            state_d = ST_IDLE;
         end
         ST_RHI: begin
            // upper word returns first, then the low word
            pc_hi_d = mem_rdata[6:0];
            status_d = mem_rdata[15:8];
            regs_d[dagen_pkg::SP_IDX] = sp - dagen_pkg::WORD_STEP;
            mem_d = '{we: 1'b0, re: 1'b1,
                      addr: sp - dagen_pkg::WORD_STEP,
                      wdata: 16'h0000};
            state_d = ST_RLO;
         end
         ST_RLO: begin
            pc_out_d = {pc_hi_q, mem_rdata};
            pop_valid_d = 1'b1;
            state_d = ST_IDLE;
         end
         ST_POP: begin
            pop_data_d = mem_rdata;
            pop_valid_d = 1'b1;
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase

      // stack stays word aligned whatever was written
      regs_d[dagen_pkg::SP_IDX][0] = 1'b0;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < dagen_pkg::NREG; i++) begin
            regs_q[i] <= dagen_pkg::REG_RESET;
         end
         regs_q[dagen_pkg::SP_IDX] <= dagen_pkg::SP_RESET;
         state_q <= ST_IDLE;
         hi_word_q <= 16'h0000;
         pc_hi_q <= 7'h00;
         src_ea_q <= '0;
         dst_ea_q <= '0;
         mem_q <= '0;
         pop_valid_q <= 1'b0;
         pop_data_q <= 16'h0000;
         pc_out_q <= 23'h000000;
         status_q <= 8'h00;
      end else begin
         for (int i = 0; i < dagen_pkg::NREG; i++) begin
            regs_q[i] <= regs_d[i];
         end
         state_q <= state_d;
         hi_word_q <= hi_word_d;
         pc_hi_q <= pc_hi_d;
         src_ea_q <= src_ea_d;
         dst_ea_q <= dst_ea_d;
         mem_q <= mem_d;
         pop_valid_q <= pop_valid_d;
         pop_data_q <= pop_data_d;
         pc_out_q <= pc_out_d;
         status_q <= status_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // second word of a call or trap frame blocks new requests for one cycle, a return for two
   assign req_ready = (state_q == ST_IDLE);
   assign src_ea = src_ea_q;
   assign dst_ea = dst_ea_q;
   assign stk_mem = mem_q;
   assign pop_valid = pop_valid_q;
   assign pop_data = pop_data_q;
   assign pc_out = pc_out_q;
   assign status_out = status_q;
   assign stack_pointer = sp;

endmodule : dagen_core

// ==== verif/dagen_props.sv ====
// Purpose: temporal checks on the address generator ports
// Assumes: one clock domain, async active-high reset
// Notes: pointer checks watch the stack pointer only
`timescale 1ns/1ps
module dagen_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // requests
   input wire logic req_valid,
   input wire dagen_pkg::dagen_req_t src_req,
   input wire logic dst_used,
   input wire logic wr_en,
   input wire logic [3:0] wr_sel,
   input wire logic [15:0] wr_data,
   input wire dagen_pkg::dagen_stkop_t stk_op,
   input wire logic [22:0] pc_in,
   input wire logic [15:0] push_data,
   input wire logic [7:0] status_low_byte,
   input wire logic [15:0] mem_rdata,
   // results
   input wire logic req_ready,
   input wire dagen_pkg::dagen_ea_t src_ea,
   input wire dagen_pkg::dagen_mem_t stk_mem,
   input wire logic pop_valid,
   input wire logic [15:0] pop_data,
   input wire logic [15:0] stack_pointer
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   logic idle;
   logic take;
   assign idle = req_ready && stk_op == dagen_pkg::SO_NONE;
   // only stack pointer requests, so the old pointer is visible
   assign take = req_valid && idle && !dst_used && !wr_en
      && src_req.ptr_sel == dagen_pkg::SP_IDX;
   sequence s_word(logic [15:0] a, logic [15:0] d);
      stk_mem.we && stk_mem.addr == a && stk_mem.wdata == d;
   endsequence
   sequence s_read(logic [15:0] a);
      stk_mem.re && stk_mem.addr == a;
   endsequence
   a_sp_reset: assert property (
      $fell(rst) |-> stack_pointer == dagen_pkg::SP_RESET)
      else $error("stack pointer reset value wrong");
   a_sp_aligned: assert property (
      !stack_pointer[0])
      else $error("stack pointer odd");
   a_sp_write: assert property (
      wr_en && wr_sel == dagen_pkg::SP_IDX && idle && !req_valid
      |=> stack_pointer == {$past(wr_data[15:1]), 1'b0})
      else $error("stack pointer write lost");
   a_push_post: assert property (
      stk_op == dagen_pkg::SO_PUSH && req_ready
      |=> s_word($past(stack_pointer), $past(push_data))
      ##0 stack_pointer == $past(stack_pointer) + 16'h0002)
      else $error("push order wrong");
   a_pop_pre: assert property (
      stk_op == dagen_pkg::SO_POP && req_ready
      |=> s_read($past(stack_pointer) - 16'h0002)
      ##0 stack_pointer == $past(stack_pointer) - 16'h0002
      ##1 pop_valid && pop_data == $past(mem_rdata))
      else $error("pop order wrong");
   a_call_frame: assert property (
      stk_op == dagen_pkg::SO_CALL && req_ready
      |=> s_word($past(stack_pointer), $past(pc_in[15:0]))
      ##1 s_word($past(stack_pointer, 2) + 16'h0002,
      {9'h000, $past(pc_in[22:16], 2)}))
      else $error("call frame wrong");
   a_trap_frame: assert property (
      stk_op == dagen_pkg::SO_TRAP && req_ready
      |=> s_word($past(stack_pointer), $past(pc_in[15:0]))
      ##1 s_word($past(stack_pointer, 2) + 16'h0002,
      {$past(status_low_byte, 2), 1'b0, $past(pc_in[22:16], 2)}))
      else $error("trap frame wrong");
   a_ret_order: assert property (
      stk_op == dagen_pkg::SO_RET && req_ready
      |=> s_read($past(stack_pointer) - 16'h0002)
      ##1 s_read($past(stack_pointer, 2) - 16'h0004) ##1 pop_valid)
      else $error("return order wrong");
   a_ind_plain: assert property (
      take && src_req.mode == dagen_pkg::AM_IND
      |=> src_ea.valid && src_ea.addr == $past(stack_pointer)
      && !src_ea.eds_ok && $stable(stack_pointer))
      else $error("plain indirect wrong");
   a_post_mod: assert property (
      take && src_req.mode == dagen_pkg::AM_POST
      |=> src_ea.addr == $past(stack_pointer) && stack_pointer
      == $past(stack_pointer) + $past(src_req.modifier))
      else $error("post modify wrong");
   a_pre_mod: assert property (
      take && src_req.mode == dagen_pkg::AM_PRE
      |=> src_ea.addr == $past(stack_pointer) + $past(src_req.modifier)
      && stack_pointer == src_ea.addr)
      else $error("pre modify wrong");
   a_file_near: assert property (
      req_valid && idle && src_req.cls == dagen_pkg::IC_FILE
      && src_req.mode == dagen_pkg::AM_FILE
      |=> src_ea.addr == {3'h0, $past(src_req.faddr)})
      else $error("file address wrong");
endmodule : dagen_props

bind dagen_core dagen_props dagen_props_i (.clk, .rst, .req_valid,
   .src_req, .dst_used, .wr_en, .wr_sel, .wr_data, .stk_op, .pc_in,
   .push_data, .status_low_byte, .mem_rdata, .req_ready, .src_ea,
   .stk_mem, .pop_valid, .pop_data, .stack_pointer);

// ==== verif/dagen_mem_model.sv ====
// Purpose: data memory behind the stack port
// Assumes: read data is due in the cycle the read strobe stands
// Notes: 256 words, wraps on address bits 8 to 1
`timescale 1ns/1ps
module dagen_mem_model (
   // clock
   input wire logic clk,
   // stack port
   input wire dagen_pkg::dagen_mem_t stk_mem,
   output logic [15:0] mem_rdata
);
   logic [15:0] mem_q [0:255];
   always @(posedge clk) begin
      if (stk_mem.we) begin
         mem_q[stk_mem.addr[8:1]] <= stk_mem.wdata;
      end
   end
   // outside a read the bus carries junk, never the stored word
   assign mem_rdata = stk_mem.re ? mem_q[stk_mem.addr[8:1]]
      : ~mem_q[stk_mem.addr[8:1]];
endmodule : dagen_mem_model

// ==== verif/dagen_core_test.sv ====
// Purpose: directed bench for the address generator core
// Assumes: memory model answers reads in the strobe cycle
// Notes: each scenario drives and judges itself, on register state left by the ones before
`timescale 1ns/1ps
module dagen_core_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic dst_used = 1'b0;
   logic wr_en = 1'b0;
   logic [3:0] wr_sel = 4'h0;
   logic [15:0] wr_data = 16'h0000;
   logic [22:0] pc_in = 23'h000000;
   logic [15:0] push_data = 16'h0000;
   logic [7:0] status_low_byte = 8'h00;
   logic frame_pointer_active_flag = 1'b0;
   logic [15:0] mem_rdata;
   dagen_pkg::dagen_req_t src_req = '0;
   dagen_pkg::dagen_req_t dst_req = '0;
   dagen_pkg::dagen_stkop_t stk_op = dagen_pkg::SO_NONE;
   dagen_pkg::dagen_ea_t src_ea;
   dagen_pkg::dagen_ea_t dst_ea;
   dagen_pkg::dagen_mem_t stk_mem;
   logic req_ready;
   logic pop_valid;
   logic [15:0] pop_data;
   logic [22:0] pc_out;
   logic [7:0] status_out;
   logic [15:0] stack_pointer;
   int errors = 0;
   int checks_done = 0;

   always #25 clk = ~clk;

   dagen_core dagen_core_i (.clk, .rst, .req_valid, .src_req, .dst_req,
      .dst_used, .wr_en, .wr_sel, .wr_data, .stk_op, .pc_in, .push_data,
      .status_low_byte, .frame_pointer_active_flag, .mem_rdata,
      .src_ea, .dst_ea, .req_ready, .stk_mem, .pop_valid, .pop_data,
      .pc_out, .status_out, .stack_pointer);
   dagen_mem_model dagen_mem_model_i (.clk, .stk_mem, .mem_rdata);

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(string n, logic [23:0] e, logic [23:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic wait_ready;
      int n;
      n = 0;
      while (req_ready !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 8) begin
            chk("ready", 24'h1, req_ready);
            finish_test();
         end
      end
   endtask : wait_ready

   task automatic op(dagen_pkg::dagen_stkop_t o, logic [15:0] d,
         logic [22:0] pc, logic [7:0] st);
      wait_ready();
      @(posedge clk);
      stk_op <= o;
      push_data <= d;
      pc_in <= pc;
      status_low_byte <= st;
      @(posedge clk);
      stk_op <= dagen_pkg::SO_NONE;
      #1;
   endtask : op

   task automatic mem_chk(logic w, logic [15:0] a, logic [15:0] d);
      chk("strobes", w ? 24'h2 : 24'h1, {stk_mem.we, stk_mem.re});
      chk("stk addr", a, stk_mem.addr);
      if (w) chk("stk data", d, stk_mem.wdata);
   endtask : mem_chk

   task automatic wr(logic [3:0] s, logic [15:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_sel <= s;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask : wr

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_push_pop;
      op(dagen_pkg::SO_PUSH, 16'hA5A5, 23'h0, 8'h00);
      mem_chk(1'b1, 16'h1000, 16'hA5A5);
      op(dagen_pkg::SO_PUSH, 16'h3C3C, 23'h0, 8'h00);
      mem_chk(1'b1, 16'h1002, 16'h3C3C);
      chk("sp", 16'h1004, stack_pointer);
      for (int i = 0; i < 2; i++) begin
         op(dagen_pkg::SO_POP, 16'h0000, 23'h0, 8'h00);
         mem_chk(1'b0, i ? 16'h1000 : 16'h1002, 16'h0000);
         @(posedge clk);
         #1;
         chk("pop", i ? 24'h1A5A5 : 24'h13C3C, {pop_valid, pop_data});
      end
   endtask : t_push_pop

   task automatic t_frame(dagen_pkg::dagen_stkop_t o, logic [22:0] pc,
         logic [7:0] st, logic [15:0] hi);
      op(o, 16'h0000, pc, st);
      mem_chk(1'b1, 16'h1000, pc[15:0]);
      chk("busy", 1'b0, req_ready);
      @(posedge clk);
      #1;
      mem_chk(1'b1, 16'h1002, hi);
      op(dagen_pkg::SO_RET, 16'h0000, 23'h0, 8'h00);
      mem_chk(1'b0, 16'h1002, 16'h0000);
      @(posedge clk);
      #1;
      mem_chk(1'b0, 16'h1000, 16'h0000);
      @(posedge clk);
      #1;
      chk("pc", {1'b1, pc}, {pop_valid, pc_out});
      chk("status", hi[15:8], status_out);
      chk("sp", 16'h1000, stack_pointer);
   endtask : t_frame

   task automatic t_mode(dagen_pkg::dagen_class_t c,
         dagen_pkg::dagen_mode_t m, logic [3:0] p, logic [15:0] md,
         logic [15:0] lit, logic [12:0] fa, logic [15:0] ea,
         logic [15:0] sp);
      wait_ready();
      @(posedge clk);
      req_valid <= 1'b1;
      dst_used <= (m == dagen_pkg::AM_INDEXED);
      src_req <= '{c, m, p, 4'h2, md, lit, fa, 1'b0, 1'b0};
      // own base field points elsewhere: only the shared one may be used
      dst_req <= '{dagen_pkg::IC_MOVE, dagen_pkg::AM_INDEXED, 4'h1, 4'h3,
         16'h0000, 16'h0000, 13'h0000, 1'b0, 1'b0};
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      chk("ea", {1'b1, ea}, {src_ea.valid, src_ea.addr});
      chk("sp", sp, stack_pointer);
      if (p == dagen_pkg::SP_IDX) chk("paged", 1'b0, src_ea.eds_ok);
      if (dst_used)
         chk("dst", 24'h10230, {dst_ea.valid, dst_ea.addr});
      if (m == dagen_pkg::AM_FILE)
         chk("dest", 24'h0, {src_ea.dest_is_reg, src_ea.dest_reg});
   endtask : t_mode

   task automatic t_modes;
      wr(4'h1, 16'h0200);
      wr(4'h2, 16'h0030);
      wr(dagen_pkg::SP_IDX, 16'h1101);
      chk("sp", 16'h1100, stack_pointer);
      t_mode(dagen_pkg::IC_THREE, dagen_pkg::AM_IND, 4'hF, 16'h0002,
         16'h0, 13'h0, 16'h1100, 16'h1100);
      t_mode(dagen_pkg::IC_THREE, dagen_pkg::AM_POST, 4'hF, 16'h0002,
         16'h0, 13'h0, 16'h1100, 16'h1102);
      t_mode(dagen_pkg::IC_THREE, dagen_pkg::AM_PRE, 4'hF, 16'hFFFC,
         16'h0, 13'h0, 16'h10FE, 16'h10FE);
      t_mode(dagen_pkg::IC_MOVE, dagen_pkg::AM_INDEXED, 4'h1, 16'h0,
         16'h0, 13'h0, 16'h0230, 16'h10FE);
      chk("bad mode", 24'h0, src_ea.bad_mode);
      t_mode(dagen_pkg::IC_MOVE, dagen_pkg::AM_LITOFF, 4'h1, 16'h0,
         16'h0010, 13'h0, 16'h0210, 16'h10FE);
      t_mode(dagen_pkg::IC_FILE, dagen_pkg::AM_FILE, 4'h5, 16'h0,
         16'h0, 13'h1ABC, 16'h1ABC, 16'h10FE);
      t_mode(dagen_pkg::IC_MOVE, dagen_pkg::AM_FILE, 4'h0, 16'h0,
         16'hC000, 13'h0, 16'hC000, 16'h10FE);
   endtask : t_modes

   task automatic t_misc;
      t_mode(dagen_pkg::IC_THREE, dagen_pkg::AM_LITERAL, 4'h1, 16'h0,
         16'hFFFF, 13'h0, 16'h0200, 16'h10FE);
      chk("lit", 24'h103FF, {src_ea.is_lit, src_ea.lit});
      t_mode(dagen_pkg::IC_THREE, dagen_pkg::AM_DIRECT, 4'h2, 16'h0,
         16'h0, 13'h0, 16'h0030, 16'h10FE);
      chk("direct", 24'h10030, {src_ea.is_lit, src_ea.lit});
      t_mode(dagen_pkg::IC_THREE, dagen_pkg::AM_INDEXED, 4'h1, 16'h0,
         16'h0, 13'h0, 16'h0230, 16'h10FE);
      chk("bad mode", 24'h1, src_ea.bad_mode);
      // frame pointer is unpaged only while its flag is set
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         frame_pointer_active_flag <= (i == 0);
         t_mode(dagen_pkg::IC_THREE, dagen_pkg::AM_IND, 4'hE, 16'h0,
            16'h0, 13'h0, 16'h0000, 16'h10FE);
         chk("fp paged", i ? 24'h1 : 24'h0, src_ea.eds_ok);
      end
   endtask : t_misc

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("sp", 16'h1000, stack_pointer);
      t_push_pop();
      t_frame(dagen_pkg::SO_CALL, 23'h5A1234, 8'hC3, 16'h005A);
      t_frame(dagen_pkg::SO_TRAP, 23'h3F8765, 8'hC3, 16'hC33F);
      t_modes();
      t_misc();
      finish_test();
   end
endmodule : dagen_core_test
